// >>> rtl/ipdc_consts.vh
// Constants for the idle and power-down controller
`ifndef IPDC_CONSTS_VH
`define IPDC_CONSTS_VH

// Clock and timing
`define IPDC_CLK_PERIOD_NS     25
`define IPDC_WAKE_PULSE_NS     40
`define IPDC_WAKE_PULSE_CYC    ((`IPDC_WAKE_PULSE_NS + `IPDC_CLK_PERIOD_NS - 1) / `IPDC_CLK_PERIOD_NS)

// Register offsets
`define IPDC_ADDR_CTRL         4'h0
`define IPDC_ADDR_STATUS       4'h1
`define IPDC_ADDR_IRQ_STAT     4'h2
`define IPDC_ADDR_IRQ_MASK     4'h3
`define IPDC_ADDR_EXT_EN       4'h4
`define IPDC_ADDR_EXT_POL      4'h5
`define IPDC_ADDR_STATE        4'h6

// Control register fields
`define IPDC_CTRL_POWERDOWN_CONFIG_BIT_BIT   5
`define IPDC_CTRL_REGOFF_BIT   0
`define IPDC_CTRL_LPDIS_BIT    1
`define IPDC_CTRL_RESET        8'h00
`define IPDC_EXT_EN_RESET      8'h00
`define IPDC_MASK_RESET        3'h0

// Interrupt status fields
`define IPDC_IRQ_IDLE_END      0
`define IPDC_IRQ_PD_WAKE       1
`define IPDC_IRQ_REFUSED       2
`define IPDC_IRQ_WIDTH         3

// Mode states
`define IPDC_ST_RUN            3'h0
`define IPDC_ST_DRAIN          3'h1
`define IPDC_ST_IDLE           3'h2
`define IPDC_ST_PD_PROT        3'h3
`define IPDC_ST_PD_INTR        3'h4
`define IPDC_ST_WAIT_RET       3'h5

`endif

// >>> rtl/ipdc_wake_filter.v
// Per-pin minimum width qualifier for fast external interrupt inputs
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_consts.vh"

module ipdc_wake_filter (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Pins
  input  wire [7:0] ext_irq_in,
  input  wire [7:0] ext_irq_en,
  input  wire [7:0] ext_irq_active_high,
  // Qualified requests
  output wire [7:0] ext_irq_valid,
  output wire [7:0] ext_irq_asserted
);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      reg [1:0] cnt;
      reg       vld;
      wire      act;
      assign act = ext_irq_en[g] & (ext_irq_in[g] == ext_irq_active_high[g]);
      assign ext_irq_asserted[g] = act;
      assign ext_irq_valid[g]    = vld;
      always @(posedge clk_sys) begin
        if (sys_rst || !act) begin
          cnt <= 2'h0;
          vld <= 1'b0;
        end else begin
          if (cnt != 2'h3)
            cnt <= cnt + 2'h1;
          // Held long enough to count as a wake request
          vld <= ({30'h0, cnt} >= (`IPDC_WAKE_PULSE_CYC - 1)); // [RQ15]
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/ipdc_top.v
// Idle and power-down mode controller
//
// Contract
// RQ1: Idle instruction halts the CPU; peripherals keep their clock.
// RQ2: Any interrupt ends Idle; execution resumes after the idle instruction post return.
// RQ3: Power-down stops internal clock and holds all units, watchdog included.
// RQ4: Pending external bus transactions finish before entering either mode.
// RQ5: Entry refused if ready enabled but not seen on last bus access.
// RQ6: With low-power oscillator as reference, main oscillator stops in power-down.
// RQ7: Running low-power oscillator adopted as reference once detected; kept unless disabled.
// RQ8: With only main oscillator, it keeps running in power-down.
// RQ9: Software sets the regulator-off bit before the power-down instruction.
// RQ10: Configuration bit 5 clear selects protected power-down.
// RQ11: Protected power-down entered only if the NMI pin is low.
// RQ12: Protected power-down leaves only on external reset pin.
// RQ13: Bit 5 set selects interruptible mode; enabled fast pins must be inactive.
// RQ14: Interruptible power-down leaves on reset, fast pin, RTC, CAN or I2C.
// RQ15: Fast interrupt pin must be held asserted at least 40ns to wake.
// RQ16: External party holds reset low long enough for clocks to settle.
// RQ17: After interrupt wake, clock restarts, units released, waking interrupt serviced.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_consts.vh"

module ipdc_top (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // CPU instruction side
  input  wire       idle_instruction,
  input  wire       enter_powerdown_instruction,
  input  wire       interrupt_return_instruction,
  input  wire       cpu_irq_request,
  output wire       cpu_halt,
  output reg        resume_after_idle,
  output reg        wake_irq_pending,
  // External bus
  input  wire       bus_busy,
  input  wire       ready_enabled,
  input  wire       ready_seen_last,
  // Pins
  input  wire       reset_input_pin_n,
  input  wire       nmi_pin_n,
  input  wire [7:0] fast_external_interrupt_input,
  // Other wake sources
  input  wire       rtc_irq,
  input  wire       can_activity_irq,
  input  wire       i2c_activity_irq,
  // Oscillators
  input  wire       lp_osc_running,
  output wire       rtc_ref_lp_osc,
  output wire       main_osc_enable,
  output wire       internal_clock_enable,
  output wire       units_hold,
  output wire       wdt_hold,
  output wire       main_regulator_off,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Interrupt
  output wire       irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] system_configuration_register;
  reg [7:0] misc_configuration_register;
  reg [7:0] ext_irq_en;
  reg [7:0] ext_irq_pol;
  reg [`IPDC_IRQ_WIDTH-1:0] irq_stat;
  reg [`IPDC_IRQ_WIDTH-1:0] irq_mask;
  reg [2:0] state;
  reg [2:0] next_state;
  reg       pend_pd;
  reg       lp_sel;
  reg [`IPDC_IRQ_WIDTH-1:0] ev;

  wire       powerdown_config_bit;
  wire       main_regulator_off_bit;
  wire       lp_disable;
  wire [7:0] ext_valid;
  wire [7:0] ext_act;
  wire       entry_ok;
  wire       pd_intr_ok;
  wire       intr_wake;
  wire       wr_ctrl;

  assign powerdown_config_bit   = system_configuration_register[`IPDC_CTRL_POWERDOWN_CONFIG_BIT_BIT];
  assign main_regulator_off_bit = misc_configuration_register[`IPDC_CTRL_REGOFF_BIT];
  assign lp_disable             = misc_configuration_register[`IPDC_CTRL_LPDIS_BIT];
  assign main_regulator_off     = main_regulator_off_bit; // [RQ9]

  //////////////////////////////////////////////////////////////////////////////
  // Fast external interrupt qualification

  ipdc_wake_filter u_filter (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .ext_irq_in          (fast_external_interrupt_input),
    .ext_irq_en          (ext_irq_en),
    .ext_irq_active_high (ext_irq_pol),
    .ext_irq_valid       (ext_valid),
    .ext_irq_asserted    (ext_act)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  assign entry_ok   = !ready_enabled || ready_seen_last; // [RQ5]
  assign pd_intr_ok = ~|ext_act; // [RQ13]
  assign intr_wake  = (|ext_valid) | rtc_irq | can_activity_irq | i2c_activity_irq; // [RQ14]

  always @* begin
    next_state = state;
    ev         = {`IPDC_IRQ_WIDTH{1'b0}};
    case (state)
      `IPDC_ST_RUN: begin
        if (idle_instruction || enter_powerdown_instruction)
          next_state = `IPDC_ST_DRAIN;
      end
      `IPDC_ST_DRAIN: begin
        if (!bus_busy) begin // [RQ4]
          if (!entry_ok) begin
            next_state = `IPDC_ST_RUN; // [RQ5]
            ev[`IPDC_IRQ_REFUSED] = 1'b1;
          end else if (!pend_pd) begin
            next_state = `IPDC_ST_IDLE; // [RQ1]
          end else if (!powerdown_config_bit) begin // [RQ10]
            if (!nmi_pin_n)
              next_state = `IPDC_ST_PD_PROT; // [RQ11]
            else begin
              next_state = `IPDC_ST_RUN;
              ev[`IPDC_IRQ_REFUSED] = 1'b1;
            end
          end else if (pd_intr_ok) begin
            next_state = `IPDC_ST_PD_INTR; // [RQ13]
          end else begin
            next_state = `IPDC_ST_RUN;
            ev[`IPDC_IRQ_REFUSED] = 1'b1;
          end
        end
      end
      `IPDC_ST_IDLE: begin
        if (cpu_irq_request) begin
          next_state = `IPDC_ST_WAIT_RET; // [RQ2]
          ev[`IPDC_IRQ_IDLE_END] = 1'b1;
        end
      end
      `IPDC_ST_WAIT_RET: begin
        if (interrupt_return_instruction)
          next_state = `IPDC_ST_RUN; // [RQ2]
      end
      `IPDC_ST_PD_PROT: begin
        next_state = `IPDC_ST_PD_PROT; // [RQ12]
      end
      `IPDC_ST_PD_INTR: begin
        if (intr_wake) begin
          next_state = `IPDC_ST_RUN; // [RQ17]
          ev[`IPDC_IRQ_PD_WAKE] = 1'b1;
        end
      end
      default: next_state = `IPDC_ST_RUN;
    endcase
  end

  // External reset pin wakes from either power-down
  always @(posedge clk_sys) begin
    if (sys_rst || !reset_input_pin_n) begin // [RQ12] [RQ14]
      state             <= `IPDC_ST_RUN;
      pend_pd           <= 1'b0;
      resume_after_idle <= 1'b0;
      wake_irq_pending  <= 1'b0;
    end else begin
      state             <= next_state;
      resume_after_idle <= (state == `IPDC_ST_WAIT_RET) && interrupt_return_instruction; // [RQ2]
      if (state == `IPDC_ST_RUN)
        pend_pd <= enter_powerdown_instruction;
      if (state == `IPDC_ST_PD_INTR && intr_wake)
        wake_irq_pending <= 1'b1; // [RQ17]
      else if (interrupt_return_instruction)
        wake_irq_pending <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock and oscillator control

  always @(posedge clk_sys) begin
    if (sys_rst || lp_disable)
      lp_sel <= 1'b0;
    else if (lp_osc_running)
      lp_sel <= 1'b1; // [RQ7]
  end

  wire in_pd;
  assign in_pd                 = (state == `IPDC_ST_PD_PROT) || (state == `IPDC_ST_PD_INTR);
  assign cpu_halt              = (state == `IPDC_ST_IDLE) || in_pd; // [RQ1]
  assign internal_clock_enable = !in_pd; // [RQ3]
  assign units_hold            = in_pd; // [RQ3]
  assign wdt_hold              = in_pd; // [RQ3]
  assign rtc_ref_lp_osc        = lp_sel;
  assign main_osc_enable       = !(in_pd && lp_sel); // [RQ6] [RQ8]

  //////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  assign wr_ctrl = reg_wr && (reg_addr == `IPDC_ADDR_CTRL);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      system_configuration_register <= `IPDC_CTRL_RESET;
      misc_configuration_register   <= `IPDC_CTRL_RESET;
      ext_irq_en                    <= `IPDC_EXT_EN_RESET;
      ext_irq_pol                   <= `IPDC_EXT_EN_RESET;
      irq_mask                      <= `IPDC_MASK_RESET;
      irq_stat                      <= {`IPDC_IRQ_WIDTH{1'b0}};
      reg_rdata                     <= 8'h00;
    end else begin
      if (wr_ctrl)
        system_configuration_register <= reg_wdata;
      if (reg_wr && reg_addr == `IPDC_ADDR_STATUS)
        misc_configuration_register <= reg_wdata;
      if (reg_wr && reg_addr == `IPDC_ADDR_EXT_EN)
        ext_irq_en <= reg_wdata;
      if (reg_wr && reg_addr == `IPDC_ADDR_EXT_POL)
        ext_irq_pol <= reg_wdata;
      if (reg_wr && reg_addr == `IPDC_ADDR_IRQ_MASK)
        irq_mask <= reg_wdata[`IPDC_IRQ_WIDTH-1:0];
      // Set wins over write-one-to-clear
      if (reg_wr && reg_addr == `IPDC_ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~reg_wdata[`IPDC_IRQ_WIDTH-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `IPDC_ADDR_CTRL:     reg_rdata <= system_configuration_register;
          `IPDC_ADDR_STATUS:   reg_rdata <= {misc_configuration_register[7:4], lp_sel,
                                             misc_configuration_register[2:0]};
          `IPDC_ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat};
          `IPDC_ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
          `IPDC_ADDR_EXT_EN:   reg_rdata <= ext_irq_en;
          `IPDC_ADDR_EXT_POL:  reg_rdata <= ext_irq_pol;
          `IPDC_ADDR_STATE:    reg_rdata <= {5'h00, state};
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

// >>> tb/ipdc_monitor.sv
// Assertion monitor for the idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module ipdc_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // CPU side
  input wire logic       cpu_irq_request,
  input wire logic       interrupt_return_instruction,
  input wire logic       cpu_halt,
  input wire logic       resume_after_idle,
  input wire logic       wake_irq_pending,
  // Bus and pins
  input wire logic       bus_busy,
  input wire logic       ready_enabled,
  input wire logic       ready_seen_last,
  input wire logic       reset_input_pin_n,
  input wire logic       nmi_pin_n,
  input wire logic       rtc_irq,
  // Clocking
  input wire logic       lp_osc_running,
  input wire logic       rtc_ref_lp_osc,
  input wire logic       main_osc_enable,
  input wire logic       internal_clock_enable,
  input wire logic       units_hold,
  input wire logic       wdt_hold,
  // Register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr
);
  logic intr_cfg;
  always @(posedge clk_sys) begin
    if (sys_rst)
      intr_cfg <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0)
      intr_cfg <= reg_wdata[5];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  chk_drain_first:
    assert property ($rose(cpu_halt) |-> !$past(bus_busy)) else $error("halt while bus busy");
  chk_ready_seen:
    assert property ($rose(cpu_halt) |-> !$past(ready_enabled) || $past(ready_seen_last))
    else $error("entry without ready");
  chk_idle_units:
    assert property (cpu_halt && internal_clock_enable |-> !units_hold && !wdt_hold) else $error("idle holds units");
  chk_idle_exit:
    assert property (cpu_halt && internal_clock_enable && cpu_irq_request |=> !cpu_halt) else $error("idle not ended");
  chk_resume_pulse:
    assert property (resume_after_idle |-> $past(interrupt_return_instruction) ##1 !resume_after_idle)
    else $error("bad resume pulse");
  chk_pd_hold:
    assert property (!internal_clock_enable |-> cpu_halt && units_hold && wdt_hold) else $error("units not held");
  chk_osc_choice:
    assert property (!internal_clock_enable |-> main_osc_enable == !rtc_ref_lp_osc) else $error("wrong oscillator");
  chk_lp_adopt:
    assert property ($rose(rtc_ref_lp_osc) |-> $past(lp_osc_running)) else $error("lp adopted while absent");
  chk_nmi_gate:
    assert property ($fell(internal_clock_enable) && !intr_cfg |-> !$past(nmi_pin_n)) else $error("entry with nmi high");
  chk_prot_stay:
    assert property (!internal_clock_enable && !intr_cfg && reset_input_pin_n |=> !internal_clock_enable)
    else $error("protected mode left");
  chk_rtc_wake:
    assert property (!internal_clock_enable && intr_cfg && rtc_irq |-> ##[1:2] internal_clock_enable && wake_irq_pending)
    else $error("no wake on rtc");
  cover property ($rose(resume_after_idle));
  cover property ($fell(internal_clock_enable) && !intr_cfg);
  cover property (!internal_clock_enable && intr_cfg ##1 internal_clock_enable);
endmodule
bind ipdc_top ipdc_monitor mon (.*);
`default_nettype wire

// >>> tb/ipdc_cpu_model.sv
// CPU model answering wake-ups with a return instruction
`timescale 1ns/1ps
`default_nettype none
module ipdc_cpu_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Controller side
  input  wire logic       cpu_halt,
  input  wire logic       wake_irq_pending,
  input  wire logic [3:0] ret_wait,
  output var  logic       interrupt_return_instruction
);
  logic       prev_halt;
  logic       prev_wake;
  logic [3:0] wait_cnt;
  initial interrupt_return_instruction = 1'b0;
  always @(posedge clk_sys) begin
    prev_halt <= cpu_halt;
    prev_wake <= wake_irq_pending;
    interrupt_return_instruction <= 1'b0;
    if (sys_rst)
      wait_cnt <= 4'h0;
    else if ((prev_halt && !cpu_halt) || (!prev_wake && wake_irq_pending))
      wait_cnt <= ret_wait;
    else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      interrupt_return_instruction <= (wait_cnt == 4'h1);
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, sys_rst, idle_instruction, enter_powerdown_instruction, interrupt_return_instruction;
  logic cpu_irq_request, cpu_halt, resume_after_idle, wake_irq_pending, bus_busy, ready_enabled;
  logic ready_seen_last, reset_input_pin_n, nmi_pin_n, rtc_irq, can_activity_irq, i2c_activity_irq;
  logic lp_osc_running, rtc_ref_lp_osc, main_osc_enable, internal_clock_enable, units_hold, wdt_hold;
  logic main_regulator_off, reg_wr, reg_rd, irq;
  logic [7:0] fast_external_interrupt_input, reg_wdata, reg_rdata;
  logic [3:0] reg_addr, ret_wait;
  int n_mismatch, comparisons;
  ipdc_top dut (.*);
  ipdc_cpu_model cpu (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task ins(input logic pd);
    @(posedge clk_sys);
    idle_instruction <= !pd;
    enter_powerdown_instruction <= pd;
    @(posedge clk_sys);
    idle_instruction <= 1'b0;
    enter_powerdown_instruction <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_idle;
    bus_busy <= 1'b1;
    ins(1'b0);
    cyc(4);
    chk(cpu_halt, 1'b0);
    bus_busy <= 1'b0;
    cyc(3);
    chk({cpu_halt, internal_clock_enable, units_hold, wdt_hold}, 8'h0C);
    cpu_irq_request <= 1'b1;
    cyc(1);
    cpu_irq_request <= 1'b0;
    cyc(1);
    chk(cpu_halt, 1'b0);
    for (int i = 0; i < 20 && resume_after_idle !== 1'b1; i++) cyc(1);
    chk(resume_after_idle, 1'b1);
    chk(irq, 1'b0);
    wr(4'h3, 8'h01);
    cyc(1);
    chk(irq, 1'b1);
    wr(4'h2, 8'h01);
    rd(4'h2, 8'h00);
    $display("t_idle done");
  endtask
  task t_ready;
    ready_enabled <= 1'b1;
    ins(1'b0);
    cyc(3);
    chk(cpu_halt, 1'b0);
    rd(4'h2, 8'h04);
    ready_enabled <= 1'b0;
    $display("t_ready done");
  endtask
  task t_prot;
    rd(4'h0, 8'h00);
    wr(4'h1, 8'h01);
    cyc(1);
    chk(main_regulator_off, 1'b1);
    ins(1'b1);
    cyc(3);
    chk(cpu_halt, 1'b0);
    nmi_pin_n <= 1'b0;
    ins(1'b1);
    cyc(3);
    chk({internal_clock_enable, units_hold, wdt_hold, main_osc_enable}, 8'h07);
    rd(4'h6, 8'h03);
    {rtc_irq, can_activity_irq, i2c_activity_irq} <= 3'h7;
    fast_external_interrupt_input <= 8'hFF;
    cyc(4);
    chk(internal_clock_enable, 1'b0);
    {rtc_irq, can_activity_irq, i2c_activity_irq, nmi_pin_n} <= 4'h1;
    fast_external_interrupt_input <= 8'h00;
    reset_input_pin_n <= 1'b0;
    cyc(4);
    reset_input_pin_n <= 1'b1;
    cyc(2);
    chk(internal_clock_enable, 1'b1);
    $display("t_prot done");
  endtask
  task t_intr;
    lp_osc_running <= 1'b1;
    cyc(3);
    chk(rtc_ref_lp_osc, 1'b1);
    wr(4'h1, 8'h03);
    cyc(2);
    chk(rtc_ref_lp_osc, 1'b0);
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h09);
    wr(4'h0, 8'h20);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h01);
    rd(4'h5, 8'h01);
    fast_external_interrupt_input <= 8'h01;
    ins(1'b1);
    cyc(3);
    chk(cpu_halt, 1'b0);
    fast_external_interrupt_input <= 8'hFE;
    for (int k = 0; k < 4; k++) begin
      ins(1'b1);
      cyc(3);
      chk(main_osc_enable, 1'b0);
      fast_external_interrupt_input <= 8'hFF;
      cyc(1);
      fast_external_interrupt_input <= 8'hFE;
      cyc(3);
      chk(internal_clock_enable, 1'b0);
      case (k)
        0: rtc_irq <= 1'b1;
        1: can_activity_irq <= 1'b1;
        2: i2c_activity_irq <= 1'b1;
        default: fast_external_interrupt_input <= 8'hFF;
      endcase
      cyc(3);
      chk({internal_clock_enable, wake_irq_pending}, 8'h03);
      {rtc_irq, can_activity_irq, i2c_activity_irq} <= 3'h0;
      fast_external_interrupt_input <= 8'hFE;
      cyc(12);
      chk(wake_irq_pending, 1'b0);
    end
    $display("t_intr done");
  endtask
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {sys_rst, reset_input_pin_n, nmi_pin_n, idle_instruction, enter_powerdown_instruction} = 5'h1C;
    {cpu_irq_request, bus_busy, ready_enabled, ready_seen_last, rtc_irq} = 5'h00;
    {can_activity_irq, i2c_activity_irq, lp_osc_running, reg_wr, reg_rd} = 5'h00;
    {fast_external_interrupt_input, reg_wdata, reg_addr, ret_wait} = 24'h00_0001;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(1);
    chk({cpu_halt, main_osc_enable, internal_clock_enable, irq}, 8'h06);
    t_idle();
    t_ready();
    ret_wait <= 4'h8;
    t_prot();
    t_intr();
    complete_run();
  end
endmodule
`default_nettype wire
